/* File: rtl/fhc_bus_cycle.v */
`include "fhc_flash_map.vh"

module fhc_bus_cycle #(
    parameter AW = 18,
    parameter DW = 16
) (
    input wire clk,
    input wire rstn,
    input wire start,
    input wire isWrite,
    input wire [AW-1:0] addr,
    input wire [DW-1:0] data,
    output reg done,
    output reg [DW-1:0] rdData,
    output reg [AW-1:0] flashAddr,
    output reg flashCeN,
    output reg flashOeN,
    output reg flashWeN,
    output reg [DW-1:0] flashDataOut,
    output reg flashDataOeN,
    input wire [DW-1:0] flashDataIn
);
    localparam [4:0] S_IDLE = 5'h01;
    localparam [4:0] S_SETUP = 5'h02;
    localparam [4:0] S_STROBE = 5'h04;
    localparam [4:0] S_HOLD = 5'h08;
    localparam [4:0] S_RECOV = 5'h10;

    localparam integer N_AS = `FHC_CYC(`FHC_T_AS_NS);
    localparam integer N_WP = `FHC_CYC(`FHC_T_WP_NS);
    localparam integer N_WPH = `FHC_CYC(`FHC_T_WPH_NS);
    localparam integer N_DH = `FHC_CYC(`FHC_T_DH_NS);
    localparam integer N_ACC = `FHC_CYC(`FHC_T_ACC_NS);
    localparam integer N_GATE_HIGH = `FHC_CYC(`FHC_GATE_HIGH_NS);
    // cycle counts cut to the counter width
    localparam [`FHC_CNT_W-1:0] C_AS = N_AS[`FHC_CNT_W-1:0];
    localparam [`FHC_CNT_W-1:0] C_WP = N_WP[`FHC_CNT_W-1:0];
    localparam [`FHC_CNT_W-1:0] C_WPH = N_WPH[`FHC_CNT_W-1:0];
    localparam [`FHC_CNT_W-1:0] C_DH = N_DH[`FHC_CNT_W-1:0];
    localparam [`FHC_CNT_W-1:0] C_ACC = N_ACC[`FHC_CNT_W-1:0];
    localparam [`FHC_CNT_W-1:0] C_GATE_HIGH = N_GATE_HIGH[`FHC_CNT_W-1:0];

    reg [4:0] state;
    reg [`FHC_CNT_W-1:0] cnt;
    reg writing;
    wire last = (cnt == {{(`FHC_CNT_W-1){1'b0}}, 1'b1});

    always @(posedge clk)
    begin
        if (!rstn)
        begin
            state <= S_IDLE;
            cnt <= {`FHC_CNT_W{1'b0}};
            writing <= 1'b0;
            done <= 1'b0;
            rdData <= {DW{1'b0}};
            flashAddr <= {AW{1'b0}};
            flashCeN <= 1'b1;
            flashOeN <= 1'b1;
            flashWeN <= 1'b1;
            flashDataOut <= {DW{1'b0}};
            flashDataOeN <= 1'b1;
        end
        else
        begin
            done <= 1'b0;
            if (!last)
                cnt <= cnt - {{(`FHC_CNT_W-1){1'b0}}, 1'b1};
            case (state)
                S_IDLE:
                    if (start)
                    begin
                        // address stays put for the whole cycle
                        flashAddr <= addr;
                        flashDataOut <= data;
                        flashDataOeN <= ~isWrite;
                        flashCeN <= 1'b0;
                        flashOeN <= 1'b1;
                        writing <= isWrite;
                        cnt <= C_AS;
                        state <= S_SETUP;
                    end
                S_SETUP:
                    if (last)
                    begin
                        // gate stays high while strobe and select are low
                        if (writing)
                            flashWeN <= 1'b0;
                        else
                            flashOeN <= 1'b0;
                        cnt <= writing ? C_WP : C_ACC;
                        state <= S_STROBE;
                    end
                S_STROBE:
                    if (last)
                    begin
                        // data taken by the device on the rising strobe
                        flashWeN <= 1'b1;
                        flashOeN <= 1'b1;
                        flashCeN <= 1'b1;
                        if (!writing)
                            rdData <= flashDataIn;
                        cnt <= C_DH;
                        state <= S_HOLD;
                    end
                S_HOLD:
                    if (last)
                    begin
                        flashDataOeN <= 1'b1;
                        // gate and select high long enough to step the toggle bit
                        cnt <= writing ? C_WPH : C_GATE_HIGH;
                        state <= S_RECOV;
                    end
                S_RECOV:
                    if (last)
                    begin
                        done <= 1'b1;
                        state <= S_IDLE;
                    end
                default:
                    state <= S_IDLE;
            endcase
        end
    end
endmodule

/* File: rtl/fhc_flash_host.v */
// Contract
// - chip erase ends with 10 at 5555
// - sector erase ends with 30 at sector
// - gate high while strobe and select low
// - toggling gate/select high at least 150 ns
// - poll on change of status bit only
// - poll address unchanged across status reads
// - command byte low, fifteen address lines
`include "fhc_flash_map.vh"

module fhc_flash_host #(
    parameter AW = 18,
    parameter DW = 16
) (
    input wire clk,
    input wire rstn,
    input wire cmdValid,
    input wire [2:0] cmdOp,
    input wire [AW-1:0] cmdAddr,
    input wire [DW-1:0] cmdData,
    output reg cmdReady,
    output reg rspValid,
    output reg [DW-1:0] rspData,
    output reg idMode,
    output reg bootLocked,
    output wire [AW-1:0] flashAddr,
    output wire flashCeN,
    output wire flashOeN,
    output wire flashWeN,
    output wire [DW-1:0] flashDataOut,
    output wire flashDataOeN,
    input wire [DW-1:0] flashDataIn
);
    localparam [6:0] S_IDLE = 7'h01;
    localparam [6:0] S_SEND = 7'h02;
    localparam [6:0] S_WAITW = 7'h04;
    localparam [6:0] S_POLL = 7'h08;
    localparam [6:0] S_WAITP = 7'h10;
    localparam [6:0] S_READ = 7'h20;
    localparam [6:0] S_WAITR = 7'h40;

    // step table: {last, address, command byte}
    function [23:0] seqStep;
        input [2:0] seqOp;
        input [2:0] idx;
        reg [23:0] unl;
        begin
            unl = {1'b0, `FHC_ADDR_CMD, `FHC_DATA_UNLOCK1};
            if (idx == 3'h1 || idx == 3'h4)
                unl = {1'b0, `FHC_ADDR_UNLOCK2, `FHC_DATA_UNLOCK2};
            seqStep = unl;
            case (seqOp)
                `FHC_OP_PROGRAM:
                    if (idx == 3'h2)
                        seqStep = {1'b0, `FHC_ADDR_CMD, `FHC_DATA_PROGRAM};
                    else if (idx == 3'h3)
                        seqStep = {1'b1, `FHC_ADDR_CMD, 8'h00};
                `FHC_OP_ID_ENTRY:
                    if (idx == 3'h2)
                        seqStep = {1'b1, `FHC_ADDR_CMD, `FHC_DATA_ID_ENTRY};
                `FHC_OP_ID_EXIT:
                    if (idx == 3'h2)
                        seqStep = {1'b1, `FHC_ADDR_CMD, `FHC_DATA_ID_EXIT};
                `FHC_OP_CHIP_ERASE, `FHC_OP_SECTOR_ERASE, `FHC_OP_BOOT_LOCK:
                    if (idx == 3'h2)
                        seqStep = {1'b0, `FHC_ADDR_CMD, `FHC_DATA_ERASE_SETUP};
                    else if (idx == 3'h5 && seqOp == `FHC_OP_CHIP_ERASE)
                        seqStep = {1'b1, `FHC_ADDR_CMD, `FHC_DATA_CHIP_ERASE};
                    else if (idx == 3'h5 && seqOp == `FHC_OP_SECTOR_ERASE)
                        seqStep = {1'b1, `FHC_ADDR_CMD, `FHC_DATA_SECTOR_ERASE};
                    else if (idx == 3'h5)
                        seqStep = {1'b1, `FHC_ADDR_CMD, `FHC_DATA_BOOT_LOCK};
                default:
                    seqStep = unl;
            endcase
        end
    endfunction

    reg [6:0] state;
    reg [2:0] op;
    reg [2:0] step;
    reg [AW-1:0] addrHold;
    reg [DW-1:0] dataHold;
    reg pollPrev;
    reg pollHave;
    reg busStart;
    reg busWrite;
    reg [AW-1:0] busAddr;
    reg [DW-1:0] busData;
    wire busDone;
    wire [DW-1:0] busRd;
    wire [23:0] stepInfo = seqStep(op, step);
    wire stepLast = stepInfo[23];
    wire pollNow = busRd[`FHC_TOGGLE_BIT];
    wire needPoll = (op != `FHC_OP_ID_ENTRY) && (op != `FHC_OP_ID_EXIT);

    fhc_bus_cycle #(
        .AW(AW),
        .DW(DW)
    ) u_cycle (
        .clk(clk),
        .rstn(rstn),
        .start(busStart),
        .isWrite(busWrite),
        .addr(busAddr),
        .data(busData),
        .done(busDone),
        .rdData(busRd),
        .flashAddr(flashAddr),
        .flashCeN(flashCeN),
        .flashOeN(flashOeN),
        .flashWeN(flashWeN),
        .flashDataOut(flashDataOut),
        .flashDataOeN(flashDataOeN),
        .flashDataIn(flashDataIn)
    );

    always @(posedge clk)
    begin
        if (!rstn)
        begin
            state <= S_IDLE;
            op <= `FHC_OP_READ;
            step <= 3'h0;
            addrHold <= {AW{1'b0}};
            dataHold <= {DW{1'b0}};
            pollPrev <= 1'b0;
            pollHave <= 1'b0;
            busStart <= 1'b0;
            busWrite <= 1'b0;
            busAddr <= {AW{1'b0}};
            busData <= {DW{1'b0}};
            cmdReady <= 1'b1;
            rspValid <= 1'b0;
            rspData <= {DW{1'b0}};
            // device starts in normal read mode after power-up
            idMode <= 1'b0;
            bootLocked <= 1'b0;
        end
        else
        begin
            busStart <= 1'b0;
            rspValid <= 1'b0;
            case (state)
                S_IDLE:
                    if (cmdValid)
                    begin
                        cmdReady <= 1'b0;
                        op <= cmdOp;
                        step <= 3'h0;
                        addrHold <= cmdAddr;
                        dataHold <= cmdData;
                        if (cmdOp == `FHC_OP_READ)
                            state <= S_READ;
                        else if (cmdOp == `FHC_OP_ID_READ)
                        begin
                            // upper lines low, lowest line picks maker or part code
                            addrHold <= {{(AW-1){1'b0}}, cmdAddr[0]};
                            state <= S_READ;
                        end
                        else
                            state <= S_SEND;
                    end
                S_SEND:
                begin
                    busStart <= 1'b1;
                    busWrite <= 1'b1;
                    // command cycles: low fifteen lines, byte in low lane only
                    busAddr <= {{(AW-15){1'b0}}, stepInfo[22:8]};
                    busData <= {{(DW-8){1'b0}}, stepInfo[7:0]};
                    if (stepLast && op == `FHC_OP_PROGRAM)
                    begin
                        busAddr <= addrHold;
                        busData <= dataHold;
                    end
                    if (stepLast && op == `FHC_OP_SECTOR_ERASE)
                        busAddr <= addrHold;
                    state <= S_WAITW;
                end
                S_WAITW:
                    if (busDone)
                    begin
                        if (!stepLast)
                        begin
                            step <= step + 3'h1;
                            state <= S_SEND;
                        end
                        else
                        begin
                            if (op == `FHC_OP_ID_ENTRY)
                                idMode <= 1'b1;
                            if (op == `FHC_OP_ID_EXIT)
                                idMode <= 1'b0;
                            if (op == `FHC_OP_BOOT_LOCK)
                                bootLocked <= 1'b1;
                            pollHave <= 1'b0;
                            if (needPoll)
                                state <= S_POLL;
                            else
                            begin
                                rspValid <= 1'b1;
                                rspData <= {DW{1'b0}};
                                cmdReady <= 1'b1;
                                state <= S_IDLE;
                            end
                        end
                    end
                S_POLL:
                begin
                    busStart <= 1'b1;
                    busWrite <= 1'b0;
                    // same address on every status read
                    busAddr <= busAddr;
                    state <= S_WAITP;
                end
                S_WAITP:
                    if (busDone)
                    begin
                        // finished once two reads agree, whatever the level
                        if (pollHave && pollNow == pollPrev)
                        begin
                            rspValid <= 1'b1;
                            rspData <= busRd;
                            cmdReady <= 1'b1;
                            state <= S_IDLE;
                        end
                        else
                        begin
                            pollPrev <= pollNow;
                            pollHave <= 1'b1;
                            state <= S_POLL;
                        end
                    end
                S_READ:
                begin
                    busStart <= 1'b1;
                    busWrite <= 1'b0;
                    busAddr <= addrHold;
                    state <= S_WAITR;
                end
                S_WAITR:
                    if (busDone)
                    begin
                        rspValid <= 1'b1;
                        rspData <= busRd;
                        cmdReady <= 1'b1;
                        state <= S_IDLE;
                    end
                default:
                    state <= S_IDLE;
            endcase
        end
    end
endmodule

/* File: rtl/fhc_flash_map.vh */
`ifndef FHC_FLASH_MAP_VH
`define FHC_FLASH_MAP_VH

// clock period and pin timing, ns
`define FHC_CLK_NS 10
`define FHC_T_AS_NS 10
`define FHC_T_WP_NS 90
`define FHC_T_WPH_NS 90
`define FHC_T_DH_NS 10
`define FHC_T_ACC_NS 120
`define FHC_GATE_HIGH_NS 150
// least times rounded up to whole cycles, never below one
`define FHC_CYC(ns) ((((ns) + `FHC_CLK_NS - 1) / `FHC_CLK_NS) < 1 ? 1 : \
    (((ns) + `FHC_CLK_NS - 1) / `FHC_CLK_NS))
`define FHC_CNT_W 5

// user operation codes
`define FHC_OP_READ 3'h0
`define FHC_OP_PROGRAM 3'h1
`define FHC_OP_CHIP_ERASE 3'h2
`define FHC_OP_SECTOR_ERASE 3'h3
`define FHC_OP_ID_ENTRY 3'h4
`define FHC_OP_ID_EXIT 3'h5
`define FHC_OP_BOOT_LOCK 3'h6
`define FHC_OP_ID_READ 3'h7

// command addresses (low fifteen lines) and command bytes
`define FHC_ADDR_CMD 15'h5555
`define FHC_ADDR_UNLOCK2 15'h2AAA
`define FHC_DATA_UNLOCK1 8'hAA
`define FHC_DATA_UNLOCK2 8'h55
`define FHC_DATA_ERASE_SETUP 8'h80
`define FHC_DATA_CHIP_ERASE 8'h10
`define FHC_DATA_SECTOR_ERASE 8'h30
`define FHC_DATA_PROGRAM 8'hA0
`define FHC_DATA_ID_ENTRY 8'h90
`define FHC_DATA_ID_EXIT 8'hF0
`define FHC_DATA_BOOT_LOCK 8'h40

// status bit watched while polling
`define FHC_TOGGLE_BIT 6

`endif

/* File: tb/fhc_flash_checker.sv */
module fhc_flash_checker #(
    parameter AW = 18,
    parameter DW = 16
) (
    input wire clk,
    input wire rstn,
    input wire cmdValid,
    input wire cmdReady,
    input wire rspValid,
    input wire bootLocked,
    input wire [AW-1:0] flashAddr,
    input wire flashCeN,
    input wire flashOeN,
    input wire flashWeN,
    input wire [DW-1:0] flashDataOut,
    input wire flashDataOeN
);
    timeunit 1ns;
    timeprecision 1ps;
    localparam int MIN_GATE_HIGH = 15;
    logic [4:0] oeHigh;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);
    // cycles the gate has stood high, saturating
    always_ff @(posedge clk)
    begin
        if (!rstn)
            oeHigh <= 5'h1F;
        else if (!flashOeN)
            oeHigh <= 5'h00;
        else if (oeHigh != 5'h1F)
            oeHigh <= oeHigh + 5'h01;
    end
    gate_high_wr_a: assert property (!flashWeN && !flashCeN |-> flashOeN)
        else $error("gate low during write strobe");
    gate_pulse_a: assert property ($fell(flashOeN) |-> oeHigh >= MIN_GATE_HIGH)
        else $error("gate high pulse too short");
    addr_steady_a: assert property (!flashCeN && !$past(flashCeN) |-> $stable(flashAddr))
        else $error("address moved inside a cycle");
    wr_pulse_a: assert property ($fell(flashWeN) |-> (!flashWeN) [*8] ##1 !flashWeN)
        else $error("write strobe too short");
    data_hold_a: assert property ($rose(flashWeN) |-> !flashDataOeN && $stable(flashDataOut))
        else $error("write data not held");
    strobe_select_a: assert property (!flashOeN || !flashWeN |-> !flashCeN)
        else $error("strobe without chip select");
    idle_quiet_a: assert property (cmdReady |-> flashCeN && flashOeN && flashWeN)
        else $error("strobe active while idle");
    take_busy_a: assert property (cmdValid && cmdReady |=> !cmdReady)
        else $error("ready after request taken");
    rsp_pulse_a: assert property (rspValid |-> cmdReady ##1 !rspValid)
        else $error("response not a ready pulse");
    lock_sticky_a: assert property (bootLocked |=> bootLocked)
        else $error("lock flag dropped");
endmodule

bind fhc_flash_host fhc_flash_checker #(.AW(AW), .DW(DW)) u_fhc_flash_checker (
    .clk(clk),
    .rstn(rstn),
    .cmdValid(cmdValid),
    .cmdReady(cmdReady),
    .rspValid(rspValid),
    .bootLocked(bootLocked),
    .flashAddr(flashAddr),
    .flashCeN(flashCeN),
    .flashOeN(flashOeN),
    .flashWeN(flashWeN),
    .flashDataOut(flashDataOut),
    .flashDataOeN(flashDataOeN)
);

/* File: tb/fhc_flash_model.sv */
`include "fhc_flash_map.vh"

module fhc_flash_model #(
    parameter int BUSY_READS = 3,
    parameter logic [15:0] MAKER_CODE = 16'h00C5, // arbitrary value
    parameter logic [15:0] PART_CODE = 16'h003A // arbitrary value
) (
    input logic powerOk,
    input logic [17:0] flashAddr,
    input logic flashCeN,
    input logic flashOeN,
    input logic flashWeN,
    input logic [15:0] flashDataOut,
    output logic [15:0] flashDataIn
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] mem [logic [17:0]];
    logic [17:0] latAddr;
    logic [15:0] lastWord = 16'h0000;
    logic [15:0] rdWord;
    logic [14:0] ca;
    logic [7:0] cb;
    logic [2:0] step = 3'h0;
    logic inId = 1'b0;
    logic locked = 1'b0;
    logic tog = 1'b1;
    int busy = 0;
    wire reading = !flashCeN && !flashOeN;
    wire writing = !flashCeN && !flashWeN;
    function automatic logic writable(input logic [17:0] a);
        return !(locked && a <= 18'h01FFF);
    endfunction
    always_comb
    begin
        if (busy > 0)
            rdWord = {9'h000, tog, 6'h00};
        else if (inId && flashAddr[17:1] == 17'h00000)
            rdWord = flashAddr[0] ? PART_CODE : MAKER_CODE;
        else
            rdWord = mem.exists(flashAddr) ? mem[flashAddr] : 16'hFFFF;
    end
    // released pins show the inverse of the last word
    assign flashDataIn = reading ? rdWord : ~lastWord;
    always @(negedge reading)
    begin
        lastWord = rdWord;
        if (busy > 0)
        begin
            tog = ~tog;
            busy = busy - 1;
        end
    end
    always @(posedge writing)
        latAddr = flashAddr;
    always @(negedge writing or negedge powerOk)
    begin
        ca = latAddr[14:0];
        cb = flashDataOut[7:0];
        if (!powerOk)
        begin
            inId = 1'b0;
            step = 3'h0;
            busy = 0;
        end
        else if (step == 3'h6)
        begin
            if (writable(latAddr))
            begin
                mem[latAddr] = flashDataOut;
                busy = BUSY_READS;
            end
            step = 3'h0;
        end
        else if (cb == `FHC_DATA_ID_EXIT)
        begin
            inId = 1'b0;
            step = 3'h0;
        end
        else if (step == 3'h0 || step == 3'h3)
            step = (ca == `FHC_ADDR_CMD && cb == `FHC_DATA_UNLOCK1) ? step + 3'h1 : 3'h0;
        else if (step == 3'h1 || step == 3'h4)
            step = (ca == `FHC_ADDR_UNLOCK2 && cb == `FHC_DATA_UNLOCK2) ? step + 3'h1 : 3'h0;
        else if (step == 3'h2)
        begin
            inId = inId || (ca == `FHC_ADDR_CMD && cb == `FHC_DATA_ID_ENTRY);
            step = ca != `FHC_ADDR_CMD ? 3'h0 : cb == `FHC_DATA_ERASE_SETUP ? 3'h3 :
                cb == `FHC_DATA_PROGRAM ? 3'h6 : 3'h0;
        end
        else
        begin
            foreach (mem[k])
                if (writable(k) && ((cb == 8'h10 && ca == 15'h5555) ||
                    (cb == 8'h30 && k[17:13] == latAddr[17:13])))
                    mem[k] = 16'hFFFF;
            locked = locked || (cb == `FHC_DATA_BOOT_LOCK && ca == `FHC_ADDR_CMD);
            busy = BUSY_READS;
            step = 3'h0;
        end
    end
endmodule

/* File: tb/testbench.sv */
`include "fhc_flash_map.vh"

module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [15:0] MAKER_CODE = 16'h00C5; // arbitrary value
    localparam logic [15:0] PART_CODE = 16'h003A; // arbitrary value
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic cmdValid = 1'b0;
    logic [2:0] cmdOp = 3'h0;
    logic [17:0] cmdAddr = 18'h00000;
    logic [15:0] cmdData = 16'h0000;
    logic cmdReady, rspValid, idMode, bootLocked, flashCeN, flashOeN, flashWeN, flashDataOeN;
    logic [17:0] flashAddr;
    logic [15:0] rspData, flashDataOut, flashDataIn;
    int fails = 0;
    int checks = 0;
    int cycles = 0;
    always #5 clk = ~clk;
    fhc_flash_host u_fhc_flash_host (
        .clk(clk), .rstn(rstn), .cmdValid(cmdValid), .cmdOp(cmdOp), .cmdAddr(cmdAddr),
        .cmdData(cmdData), .cmdReady(cmdReady), .rspValid(rspValid), .rspData(rspData),
        .idMode(idMode), .bootLocked(bootLocked), .flashAddr(flashAddr), .flashCeN(flashCeN),
        .flashOeN(flashOeN), .flashWeN(flashWeN), .flashDataOut(flashDataOut),
        .flashDataOeN(flashDataOeN), .flashDataIn(flashDataIn));
    fhc_flash_model #(.MAKER_CODE(MAKER_CODE), .PART_CODE(PART_CODE)) u_fhc_flash_model (
        .powerOk(rstn), .flashAddr(flashAddr), .flashCeN(flashCeN), .flashOeN(flashOeN),
        .flashWeN(flashWeN), .flashDataOut(flashDataOut), .flashDataIn(flashDataIn));
    task automatic give_verdict();
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    always @(posedge clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 20000)
        begin
            fails = fails + 1;
            give_verdict();
        end
    end
    task automatic check_word(input string what, input logic [15:0] exp, input logic [15:0] got);
        checks++;
        if (got !== exp)
        begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic check_bit(input string what, input logic exp, input logic got);
        checks++;
        if (got !== exp)
        begin
            fails++;
            $display("[FAIL] %s expected %b seen %b", what, exp, got);
        end
    endtask
    task automatic run_op(input logic [2:0] op, input logic [17:0] a, input logic [15:0] d);
        int n;
        n = 0;
        cmdOp <= op;
        cmdAddr <= a;
        cmdData <= d;
        cmdValid <= 1'b1;
        @(posedge clk);
        while (cmdReady !== 1'b1)
            @(posedge clk);
        cmdValid <= 1'b0;
        while (rspValid !== 1'b1 && n < 3000)
        begin
            @(posedge clk);
            n++;
        end
        check_bit("response", 1'b1, rspValid);
    endtask
    task automatic test_program_erase();
        run_op(`FHC_OP_PROGRAM, 18'h04123, 16'h5A3C);
        check_word("poll result", 16'h5A3C, rspData);
        run_op(`FHC_OP_PROGRAM, 18'h0A456, 16'hC3E5);
        check_word("poll result", 16'hC3E5, rspData);
        run_op(`FHC_OP_SECTOR_ERASE, 18'h04000, 16'h0000);
        run_op(`FHC_OP_READ, 18'h04123, 16'h0000);
        check_word("erased word", 16'hFFFF, rspData);
        run_op(`FHC_OP_READ, 18'h0A456, 16'h0000);
        check_word("kept word", 16'hC3E5, rspData);
        run_op(`FHC_OP_CHIP_ERASE, 18'h00000, 16'h0000);
        run_op(`FHC_OP_READ, 18'h0A456, 16'h0000);
        check_word("chip erased", 16'hFFFF, rspData);
        $display("test_program_erase done");
    endtask
    task automatic test_id_mode();
        run_op(`FHC_OP_ID_ENTRY, 18'h00000, 16'h0000);
        check_bit("idMode", 1'b1, idMode);
        run_op(`FHC_OP_ID_READ, 18'h00000, 16'h0000);
        check_word("maker code", MAKER_CODE, rspData);
        run_op(`FHC_OP_ID_READ, 18'h00001, 16'h0000);
        check_word("part code", PART_CODE, rspData);
        run_op(`FHC_OP_ID_EXIT, 18'h00000, 16'h0000);
        check_bit("idMode", 1'b0, idMode);
        run_op(`FHC_OP_READ, 18'h00001, 16'h0000);
        check_word("normal read", 16'hFFFF, rspData);
        run_op(`FHC_OP_ID_ENTRY, 18'h00000, 16'h0000);
        rstn <= 1'b0;
        repeat (5) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        check_bit("idMode", 1'b0, idMode);
        run_op(`FHC_OP_READ, 18'h00000, 16'h0000);
        check_word("power read", 16'hFFFF, rspData);
        $display("test_id_mode done");
    endtask
    task automatic test_boot_lock();
        run_op(`FHC_OP_BOOT_LOCK, 18'h00000, 16'h0000);
        check_bit("bootLocked", 1'b1, bootLocked);
        run_op(`FHC_OP_PROGRAM, 18'h01FFF, 16'h1234);
        check_word("locked word", 16'hFFFF, rspData);
        run_op(`FHC_OP_PROGRAM, 18'h02000, 16'h1234);
        check_word("open word", 16'h1234, rspData);
        $display("test_boot_lock done");
    endtask
    initial
    begin
        repeat (5) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        test_program_erase();
        test_id_mode();
        test_boot_lock();
        give_verdict();
    end
endmodule
